// File: bench/tb_line_unit_global_clock_irq_regs.sv
`timescale 1ns/10ps
module tb_line_unit_global_clock_irq_regs;
    // ****************************************
    // Signals
    // ****************************************
    localparam logic [15:0] rateAddr = line_unit_pkg::CLK_RATE_ADDR;
    localparam logic [15:0] statAddr = line_unit_pkg::IRQ_STATUS_ADDR;
    logic core_clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [15:0] awaddr, araddr, masterClockKhz;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, chanIrqEvent, inputClockRateCode;
    logic [1:0] bresp, rresp, rs;
    int error_cnt, n_compared;
    logic [15:0] khzTable [16] = '{16'h0800, 16'h0608, 16'h0008, 16'h0010, 16'h0038, 16'h0040,
        16'h0080, 16'h0100, 16'h1000, 16'h0C10, 16'h2000, 16'h1820, 16'h4000, 16'h3040,
        16'h0800, 16'h0608};

    line_unit_global_clock_irq_regs line_unit_global_clock_irq_regs_i (
        .core_clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .chanIrqEvent, .inputClockRateCode, .masterClockKhz);

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axiWrite(input logic [15:0] a, input logic [31:0] d);
        bit got;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        got = 0;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) got = 1;
        end
        rs = bresp;
        bready <= 1'b0;
        chk(32'(got), 32'h1);
    endtask

    task automatic axiRead(input logic [15:0] a);
        bit got;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        got = 0;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) got = 1;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        chk(32'(got), 32'h1);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic testReset();
        chk(32'(inputClockRateCode), 32'h0000000C);
        chk(32'(masterClockKhz), 32'h00004000);
        axiRead(rateAddr);
        chk(rd, 32'h0000000C);
        chk(32'(rs), 32'(line_unit_pkg::RESP_OKAY));
        axiRead(statAddr);
        chk(rd, 32'h00000000);
    endtask

    task automatic testCodes();
        for (int c = 0; c < 16; c++) begin
            axiWrite(rateAddr, {24'h000000, 4'hA, 4'(c)});
            chk(32'(rs), 32'(line_unit_pkg::RESP_OKAY));
            repeat (2) @(posedge core_clk);
            chk(32'(inputClockRateCode), 32'(c));
            chk(32'(masterClockKhz), 32'(khzTable[c]));
            axiRead(rateAddr);
            chk(rd, {24'h000000, 4'hA, 4'(c)});
        end
    endtask

    task automatic testIrq();
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            chanIrqEvent <= 4'(1 << i);
            @(posedge core_clk);
            chanIrqEvent <= 4'h0;
            axiRead(statAddr);
            chk(rd, 32'(1 << i));
            axiRead(statAddr);
            chk(rd, 32'h00000000);
        end
        @(posedge core_clk);
        chanIrqEvent <= 4'hF;
        axiRead(statAddr);
        chanIrqEvent <= 4'h0;
        chk(rd, 32'h0000000F);
        axiRead(statAddr);
        chk(rd, 32'h0000000F);
        axiRead(statAddr);
        chk(rd, 32'h00000000);
    endtask

    task automatic testRefuse();
        axiWrite(16'h0010, 32'h00000055);
        chk(32'(rs), 32'(line_unit_pkg::RESP_SLVERR));
        chk(32'(inputClockRateCode), 32'h0000000F);
        wstrb <= 4'h0;
        axiWrite(rateAddr, 32'h00000003);
        wstrb <= 4'hF;
        chk(32'(rs), 32'(line_unit_pkg::RESP_OKAY));
        chk(32'(inputClockRateCode), 32'h0000000F);
        axiRead(rateAddr);
        chk(rd, 32'h000000AF);
        axiRead(16'h0010);
        chk(32'(rs), 32'(line_unit_pkg::RESP_SLVERR));
        chk(rd, 32'h00000000);
        axiWrite(statAddr, 32'h000000FF);
        chk(32'(rs), 32'(line_unit_pkg::RESP_OKAY));
        axiRead(statAddr);
        chk(rd, 32'h00000000);
    endtask

    // ****************************************
    // Run control
    // ****************************************
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end

    initial begin
        resetn <= 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        awaddr <= 16'h0000;
        araddr <= 16'h0000;
        wdata <= 32'h00000000;
        wstrb <= 4'hF;
        chanIrqEvent <= 4'h0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        testReset();
        testCodes();
        testIrq();
        testRefuse();
        complete_run();
    end
endmodule // tb_line_unit_global_clock_irq_regs

// File: src/clock_rate_decode.sv
`timescale 1ns/10ps
module clock_rate_decode (
    input wire logic [line_unit_pkg::RATE_CODE_W-1:0] rateCode,
    output logic [line_unit_pkg::KHZ_W-1:0] rateKhz
);

    // ****************************************
    // Master clock frequency in kHz per code
    // ****************************************
    always_comb begin
        case (rateCode)
            4'h0: rateKhz = 16'h0800;
            4'h1: rateKhz = 16'h0608;
            4'h2: rateKhz = 16'h0008;
            4'h3: rateKhz = 16'h0010;
            4'h4: rateKhz = 16'h0038;
            4'h5: rateKhz = 16'h0040;
            4'h6: rateKhz = 16'h0080;
            4'h7: rateKhz = 16'h0100;
            4'h8: rateKhz = 16'h1000;
            4'h9: rateKhz = 16'h0C10;
            4'hA: rateKhz = 16'h2000;
            4'hB: rateKhz = 16'h1820;
            4'hC: rateKhz = 16'h4000;
            4'hD: rateKhz = 16'h3040;
            4'hE: rateKhz = 16'h0800;
            default: rateKhz = 16'h0608;
        endcase
    end

endmodule // clock_rate_decode

// File: src/line_unit_global_clock_irq_regs.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
module line_unit_global_clock_irq_regs (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [line_unit_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [line_unit_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [line_unit_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [line_unit_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [line_unit_pkg::CHAN_COUNT-1:0] chanIrqEvent,
    output logic [line_unit_pkg::RATE_CODE_W-1:0] inputClockRateCode,
    output logic [line_unit_pkg::KHZ_W-1:0] masterClockKhz
);

    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    line_unit_pkg::read_beat_type rbeat_reg;
    line_unit_pkg::read_beat_type rbeat_next;
    logic [line_unit_pkg::ADDR_W-1:0] awaddr_reg;
    logic [line_unit_pkg::DATA_W-1:0] wdata_reg;
    logic wlane0_reg;
    logic [line_unit_pkg::REG_W-1:0] clkRate_reg;
    logic [line_unit_pkg::CHAN_COUNT-1:0] irqFlag_reg;
    logic [line_unit_pkg::KHZ_W-1:0] khz_reg;
    logic [line_unit_pkg::KHZ_W-1:0] khz_next;
    logic writeFire;
    logic readFire;
    logic readStatus;

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rbeat_reg.data;
    assign rresp = rbeat_reg.resp;
    assign inputClockRateCode = clkRate_reg[line_unit_pkg::RATE_CODE_W-1:0];
    assign masterClockKhz = khz_reg;

    function automatic logic isMapped(input logic [line_unit_pkg::ADDR_W-1:0] addr);
        if (addr == line_unit_pkg::CLK_RATE_ADDR) begin
            isMapped = 1'b1;
        end else if (addr == line_unit_pkg::IRQ_STATUS_ADDR) begin
            isMapped = 1'b1;
        end else begin
            isMapped = 1'b0;
        end
    endfunction

    // ****************************************
    // Write channel
    // ****************************************
    assign writeFire = !awready_reg && !wready_reg && !bvalid_reg;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= line_unit_pkg::RESP_OKAY;
            awaddr_reg <= 16'h0000;
            wdata_reg <= 32'h00000000;
            wlane0_reg <= 1'b0;
        end else begin
            if (awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                awaddr_reg <= awaddr;
            end
            if (wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                wdata_reg <= wdata;
                wlane0_reg <= wstrb[0];
            end
            if (writeFire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= isMapped(awaddr_reg) ? line_unit_pkg::RESP_OKAY
                                                  : line_unit_pkg::RESP_SLVERR;
            end
            if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // Clock rate select register
    // ****************************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            clkRate_reg <= line_unit_pkg::CLK_RATE_RST;
        end else if (writeFire && wlane0_reg && awaddr_reg == line_unit_pkg::CLK_RATE_ADDR) begin
            clkRate_reg <= wdata_reg[line_unit_pkg::REG_W-1:0];
        end
    end

    clock_rate_decode rateDecode (
        .rateCode(clkRate_reg[line_unit_pkg::RATE_CODE_W-1:0]),
        .rateKhz(khz_next)
    );

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            khz_reg <= 16'h4000;
        end else begin
            khz_reg <= khz_next;
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    assign readFire = arvalid && arready_reg;
    assign readStatus = readFire && araddr == line_unit_pkg::IRQ_STATUS_ADDR;

    always_comb begin
        rbeat_next.resp = line_unit_pkg::RESP_OKAY;
        rbeat_next.data = 32'h00000000;
        if (araddr == line_unit_pkg::CLK_RATE_ADDR) begin
            rbeat_next.data[line_unit_pkg::REG_W-1:0] = clkRate_reg;
        end else if (araddr == line_unit_pkg::IRQ_STATUS_ADDR) begin
            rbeat_next.data[line_unit_pkg::CHAN_COUNT-1:0] = irqFlag_reg;
        end else begin
            rbeat_next.resp = line_unit_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rbeat_reg <= '0;
        end else if (readFire) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rbeat_reg <= rbeat_next;
        end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // ****************************************
    // Channel interrupt flags
    // ****************************************
    genvar ch;
    generate
        for (ch = 0; ch < line_unit_pkg::CHAN_COUNT; ch++) begin : gFlag
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    irqFlag_reg[ch] <= 1'b0;
                end else if (chanIrqEvent[ch]) begin
                    irqFlag_reg[ch] <= 1'b1;
                end else if (readStatus) begin
                    irqFlag_reg[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************
    // Assertions
    // ****************************************
    a_rate_repeat: assert property (@(posedge core_clk) disable iff (!resetn)
        clkRate_reg[3:0] == 4'hE |=> masterClockKhz == 16'h0800)
        else $error("Code 1110 did not give 2.048 MHz");

    a_flag_sets: assert property (@(posedge core_clk) disable iff (!resetn)
        chanIrqEvent[0] |=> irqFlag_reg[0])
        else $error("Channel 0 event did not set its flag");

    a_flag_holds: assert property (@(posedge core_clk) disable iff (!resetn)
        irqFlag_reg[1] && !readStatus |=> irqFlag_reg[1])
        else $error("Channel 1 flag dropped without a read");

    a_read_reports: assert property (@(posedge core_clk) disable iff (!resetn)
        readStatus |=> rdata[3:0] == $past(irqFlag_reg) && rvalid)
        else $error("Status read did not return the flags");

    a_read_clears: assert property (@(posedge core_clk) disable iff (!resetn)
        readStatus && chanIrqEvent == 4'h0 |=> irqFlag_reg == 4'h0)
        else $error("Status read did not clear the flags");

    a_reserved_zero: assert property (@(posedge core_clk) disable iff (!resetn)
        readStatus |=> rdata[31:4] == 28'h0000000)
        else $error("Reserved status bits not zero");

    a_reset_code: assert property (@(posedge core_clk)
        !$past(resetn) && resetn |-> clkRate_reg == 8'h0C)
        else $error("Rate register not at reset value");

    c_status_read: cover property (@(posedge core_clk) disable iff (!resetn)
        readStatus && irqFlag_reg != 4'h0);
    c_event_on_clear: cover property (@(posedge core_clk) disable iff (!resetn)
        readStatus && chanIrqEvent != 4'h0);
    c_rate_write: cover property (@(posedge core_clk) disable iff (!resetn)
        writeFire && awaddr_reg == line_unit_pkg::CLK_RATE_ADDR);

endmodule // line_unit_global_clock_irq_regs

// File: src/line_unit_pkg.sv
package line_unit_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam logic [11:0] CLK_RATE_IDX = 12'hFE9;
    localparam logic [11:0] IRQ_STATUS_IDX = 12'hFEA;
    localparam logic [ADDR_W-1:0] CLK_RATE_ADDR = {2'h0, CLK_RATE_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = {2'h0, IRQ_STATUS_IDX, 2'h0};

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int RATE_CODE_LSB = 0;
    localparam int RATE_CODE_W = 4;
    localparam int CHAN_COUNT = 4;
    localparam int REG_W = 8;
    localparam int KHZ_W = 16;
    localparam logic [RATE_CODE_W-1:0] RATE_CODE_RST = 4'hC;
    localparam logic [REG_W-1:0] CLK_RATE_RST = 8'h0C;
    localparam logic [REG_W-1:0] IRQ_STATUS_RST = 8'h00;

    // ****************************************
    // Bus responses
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] resp;
        logic [DATA_W-1:0] data;
    } read_beat_type;

endpackage
